// ### crypto_ctrl_checker.sv
// Port checker for the crypto session control block, bound to its ports.
// Assumes a master that holds each request until waitrequest falls.
`timescale 1ns/1ps
`default_nettype none
module crypto_ctrl_checker
  import crypto_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Register bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Status pins
  input wire logic        engine_ready,
  input wire logic        busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic req;
  logic acc;
  logic go;
  // Decode of request, acceptance and go; go needs lane 0
  assign req = read | write;
  assign acc = req & ~waitrequest;
  assign go = acc & write & (address == OFS_CONTROL) & writedata[CTRL_GO_BIT]
              & byteenable[0] & ~busy & engine_ready;

  chk_wait_first: assert property (req && !$past(req) |-> waitrequest)
    else $error("waitrequest low in first request cycle");
  chk_wait_once: assert property (req && waitrequest ##1 req |-> !waitrequest)
    else $error("request not answered after one wait cycle");
  chk_idle_nowait: assert property (!req |-> !waitrequest)
    else $error("waitrequest high with no request");
  chk_go_busy: assert property (go |=> busy)
    else $error("accepted command did not start");
  chk_busy_cause: assert property ($rose(busy) |-> $past(go))
    else $error("busy without an accepted command");
  chk_busy_pulse: assert property (busy |=> !busy)
    else $error("busy longer than one cycle");
  chk_ready_rise: assert property (!engine_ready |=> engine_ready)
    else $error("engine ready late after reset");
  chk_ready_hold: assert property (engine_ready |=> engine_ready)
    else $error("engine ready dropped");
  chk_ready_reg: assert property (acc && read && address == OFS_DEV_STATUS
    |-> readdata == {31'h0, engine_ready})
    else $error("status word disagrees with ready pin");
  chk_svc_mask: assert property (acc && read && address == OFS_SERVICES
    |-> readdata == {27'h0, SERVICES_OFFERED})
    else $error("service mask wrong");

  cover property (go);
  cover property (busy ##3 acc && read);
  cover property (acc && write && address == OFS_FEATURES);
endmodule // crypto_ctrl_checker

bind crypto_session_control crypto_ctrl_checker chk (
  .core_clk(core_clk), .resetn(resetn), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .engine_ready(engine_ready), .busy(busy)
);
`default_nettype wire

// ### crypto_ctrl_pkg.sv
// Constants, register map and carrier types of the crypto session control block.
// Assumes a single 10 MHz core clock and an Avalon-MM slave with byte addresses.
package crypto_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_DEV_STATUS    = 8'h00;
  localparam logic [7:0] OFS_FEATURES      = 8'h04;
  localparam logic [7:0] OFS_SERVICES      = 8'h08;
  localparam logic [7:0] OFS_CIPHER_ALGO_L = 8'h0C;
  localparam logic [7:0] OFS_CIPHER_ALGO_H = 8'h10;
  localparam logic [7:0] OFS_HASH_ALGO     = 8'h14;
  localparam logic [7:0] OFS_MAC_ALGO_L    = 8'h18;
  localparam logic [7:0] OFS_MAC_ALGO_H    = 8'h1C;
  localparam logic [7:0] OFS_AEAD_ALGO     = 8'h20;
  localparam logic [7:0] OFS_AKC_ALGO      = 8'h24;
  localparam logic [7:0] OFS_MAX_AUTH_KEY  = 8'h28;
  localparam logic [7:0] OFS_CONTROL       = 8'h2C;
  localparam logic [7:0] OFS_REQ_STATE     = 8'h30;
  localparam logic [7:0] OFS_FLF_LEN       = 8'h34;
  localparam logic [7:0] OFS_VLF_LEN       = 8'h38;
  localparam logic [7:0] OFS_RES_HANDLE_LO = 8'h40;
  localparam logic [7:0] OFS_RES_HANDLE_HI = 8'h44;
  localparam logic [7:0] OFS_RES_STATUS    = 8'h48;
  localparam logic [7:0] OFS_RES_PAD       = 8'h4C;
  localparam logic [7:0] OFS_REQ_BUF       = 8'h80;
  localparam int         REQ_WORDS         = 18;

  // Request buffer word positions
  localparam int W_OPCODE  = 0;
  localparam int W_ALGO    = 1;
  localparam int W_FLAG    = 2;
  localparam int W_FLF0    = 4;
  localparam int W_FLF1    = 5;
  localparam int W_FLF2    = 6;

  // Field positions
  localparam int READY_BIT       = 0;
  localparam int FEAT_REVISED    = 5;
  localparam int CTRL_GO_BIT     = 0;
  localparam int CTRL_CLR_BIT    = 1;
  localparam int STATE_BUSY_BIT  = 0;
  localparam int STATE_DONE_BIT  = 1;
  localparam int FLAG_STATELESS  = 0;
  localparam int SVC_SHIFT       = 8;

  // Offered capabilities, values after reset
  localparam logic [4:0]  SERVICES_OFFERED = 5'h1F;
  localparam logic [63:0] CIPHER_ALGO_MASK = 64'h0000_0000_0000_0006;
  localparam logic [31:0] HASH_ALGO_MASK   = 32'h0000_0006;
  localparam logic [63:0] MAC_ALGO_MASK    = 64'h0000_0000_0000_0014;
  localparam logic [31:0] AEAD_ALGO_MASK   = 32'h0000_0002;
  localparam logic [31:0] AKC_ALGO_MASK    = 32'h0000_0002;
  localparam logic [31:0] MAX_AUTH_KEY_LEN = 32'h0000_0040;
  localparam logic [5:0]  FEATURES_RESET   = 6'h00;

  // Services and operation codes
  localparam logic [7:0] SVC_CIPHER   = 8'h00;
  localparam logic [7:0] SVC_HASH     = 8'h01;
  localparam logic [7:0] SVC_MAC      = 8'h02;
  localparam logic [7:0] SVC_AEAD     = 8'h03;
  localparam logic [7:0] SVC_AKC      = 8'h04;
  localparam logic [7:0] OP_CREATE    = 8'h02;
  localparam logic [7:0] OP_DESTROY   = 8'h03;
  localparam logic [7:0] OP_AKC_CREATE  = 8'h04;
  localparam logic [7:0] OP_AKC_DESTROY = 8'h05;

  // Fixed area lengths in bytes
  localparam logic [15:0] LEGACY_FLF_LEN  = 16'h0038;
  localparam logic [15:0] SYM_FLF_LEN     = 16'h0038;
  localparam logic [15:0] HASH_FLF_LEN    = 16'h0008;
  localparam logic [15:0] MAC_FLF_LEN     = 16'h0010;
  localparam logic [15:0] AEAD_FLF_LEN    = 16'h0018;
  localparam logic [15:0] AKC_FLF_LEN     = 16'h0038;
  localparam logic [15:0] DESTROY_FLF_LEN = 16'h0008;

  // Status codes
  localparam logic [31:0] status_ok             = 32'h0000_0000;
  localparam logic [31:0] status_error          = 32'h0000_0001;
  localparam logic [31:0] status_auth_failed    = 32'h0000_0002;
  localparam logic [31:0] status_unsupported    = 32'h0000_0003;
  localparam logic [31:0] status_invalid_handle = 32'h0000_0004;
  localparam logic [31:0] status_no_free_handle = 32'h0000_0005;
  localparam logic [31:0] status_key_rejected   = 32'h0000_0006;

  // Session table
  localparam int SESSIONS = 8;
  localparam int IDX_W    = 3;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } state_t;

  typedef struct packed {
    logic [63:0] handle;
    logic [31:0] status;
  } result_t;

  typedef struct packed {
    logic             alloc;
    logic             free;
    logic [IDX_W-1:0] index;
    logic [2:0]       service;
  } pool_req_t;

  typedef struct packed {
    logic                        avail;
    logic [IDX_W-1:0]            first;
    logic [SESSIONS-1:0]         valid;
    logic [SESSIONS-1:0][2:0]    owner;
  } pool_stat_t;

endpackage

// ### crypto_session_control.sv
// Control-queue interpreter: takes a staged control request, creates or
// destroys sessions and writes the result area. Registers sit behind an
// Avalon-MM slave with one wait state; the driver stages the request words
// and lengths, then writes the go bit.
`timescale 1ns/1ps
`default_nettype none
module crypto_session_control
  import crypto_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Status pins
  output logic             engine_ready,
  output logic             busy
);
  import crypto_ctrl_pkg::*;

  // Byte-lane merge for writable registers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Is an algorithm id offered by a 64-bit mask
  function automatic logic algo_offered(input logic [63:0] mask,
                                        input logic [31:0] id);
    logic hit;
    hit = 1'b0;
    if (id < 32'h0000_0040) begin
      hit = mask[id[5:0]];
    end
    return hit;
  endfunction

  // Bus handshake state
  logic        ack;
  logic        next_ack;
  logic [31:0] next_readdata;
  logic        wr_acc;
  logic        buf_hit;
  logic [4:0]  buf_idx;

  // Software-visible state
  logic [5:0]  features;
  logic [5:0]  next_features;
  logic [15:0] flf_len;
  logic [15:0] next_flf_len;
  logic [15:0] vlf_len;
  logic [15:0] next_vlf_len;
  logic [31:0] req_buf      [REQ_WORDS];
  logic [31:0] next_req_buf [REQ_WORDS];
  logic        done;
  logic        next_done;
  logic        go;
  logic        next_engine_ready;

  // Interpreter state
  state_t      state;
  state_t      next_state;
  result_t     result;
  result_t     next_result;
  pool_req_t   pool_req;
  pool_stat_t  pool_stat;

  // Decode helpers
  logic [31:0] opcode;
  logic [7:0]  svc;
  logic [7:0]  op;
  logic        is_create;
  logic        is_destroy;
  logic [15:0] want_flf;
  logic        algo_ok;
  logic [63:0] dest_handle;
  logic [IDX_W-1:0] dest_idx;
  logic        dest_ok;

  // One wait state: the first cycle of a request is held off
  assign waitrequest = (read | write) & ~ack;
  assign wr_acc      = write & ack;
  assign buf_hit     = (address >= OFS_REQ_BUF) &&
                       (address < 8'(OFS_REQ_BUF + 8'(4 * REQ_WORDS)));
  assign buf_idx     = 5'((address - OFS_REQ_BUF) >> 2);
  assign busy        = (state == ST_EXEC);

  // Handshake and read mux; unmapped addresses read as zero
  always_comb begin
    next_ack      = (read | write) & ~ack;
    next_readdata = readdata;
    if (read && !ack) begin
      next_readdata = 32'h0000_0000;
      case (address)
        OFS_DEV_STATUS:    next_readdata[READY_BIT] = engine_ready;
        OFS_FEATURES:      next_readdata = {26'h0, features};
        OFS_SERVICES:      next_readdata = {27'h0, SERVICES_OFFERED};
        OFS_CIPHER_ALGO_L: next_readdata = CIPHER_ALGO_MASK[31:0];
        OFS_CIPHER_ALGO_H: next_readdata = CIPHER_ALGO_MASK[63:32];
        OFS_HASH_ALGO:     next_readdata = HASH_ALGO_MASK;
        OFS_MAC_ALGO_L:    next_readdata = MAC_ALGO_MASK[31:0];
        OFS_MAC_ALGO_H:    next_readdata = MAC_ALGO_MASK[63:32];
        OFS_AEAD_ALGO:     next_readdata = AEAD_ALGO_MASK;
        OFS_AKC_ALGO:      next_readdata = AKC_ALGO_MASK;
        OFS_MAX_AUTH_KEY:  next_readdata = MAX_AUTH_KEY_LEN;
        OFS_REQ_STATE: begin
          next_readdata[STATE_BUSY_BIT] = busy;
          next_readdata[STATE_DONE_BIT] = done;
        end
        OFS_FLF_LEN:       next_readdata = {16'h0, flf_len};
        OFS_VLF_LEN:       next_readdata = {16'h0, vlf_len};
        OFS_RES_HANDLE_LO: next_readdata = result.handle[31:0];
        OFS_RES_HANDLE_HI: next_readdata = result.handle[63:32];
        OFS_RES_STATUS:    next_readdata = result.status;
        default: begin
          if (buf_hit) begin
            next_readdata = req_buf[buf_idx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack      <= next_ack;
      readdata <= next_readdata;
    end
  end

  // Register writes; staging is frozen while a request executes
  always_comb begin
    next_features     = features;
    next_flf_len      = flf_len;
    next_vlf_len      = vlf_len;
    next_req_buf      = req_buf;
    next_done         = done;
    next_engine_ready = 1'b1;
    go                = 1'b0;
    if (wr_acc && !busy) begin
      case (address)
        OFS_FEATURES: begin
          next_features = 6'(be_merge({26'h0, features}, writedata, byteenable));
        end
        OFS_FLF_LEN: begin
          next_flf_len = 16'(be_merge({16'h0, flf_len}, writedata, byteenable));
        end
        OFS_VLF_LEN: begin
          next_vlf_len = 16'(be_merge({16'h0, vlf_len}, writedata, byteenable));
        end
        OFS_CONTROL: begin
          // Go is ignored until the engine reports ready
          go = byteenable[0] & writedata[CTRL_GO_BIT] & engine_ready;
          if (byteenable[0] && writedata[CTRL_CLR_BIT]) begin
            next_done = 1'b0;
          end
        end
        default: begin
          if (buf_hit) begin
            next_req_buf[buf_idx] = be_merge(req_buf[buf_idx], writedata, byteenable);
          end
        end
      endcase
    end
    // Completion beats a clear in the same cycle
    if (state == ST_EXEC) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      features     <= FEATURES_RESET;
      flf_len      <= 16'h0000;
      vlf_len      <= 16'h0000;
      done         <= 1'b0;
      engine_ready <= 1'b0;
      for (int i = 0; i < REQ_WORDS; i++) begin
        req_buf[i] <= 32'h0000_0000;
      end
    end else begin
      features     <= next_features;
      flf_len      <= next_flf_len;
      vlf_len      <= next_vlf_len;
      done         <= next_done;
      engine_ready <= next_engine_ready;
      req_buf      <= next_req_buf;
    end
  end

  // Header decode
  always_comb begin
    opcode     = req_buf[W_OPCODE];
    svc        = opcode[SVC_SHIFT +: 8];
    op         = opcode[7:0];
    is_create  = 1'b0;
    is_destroy = 1'b0;
    if (opcode[31:16] == 16'h0000 && svc <= SVC_AKC &&
        SERVICES_OFFERED[svc[2:0]]) begin
      if (svc == SVC_AKC) begin
        is_create  = (op == OP_AKC_CREATE);
        is_destroy = (op == OP_AKC_DESTROY);
      end else begin
        is_create  = (op == OP_CREATE);
        is_destroy = (op == OP_DESTROY);
      end
    end
  end

  // Expected fixed area length and algorithm check
  always_comb begin
    want_flf = DESTROY_FLF_LEN;
    algo_ok  = 1'b0;
    if (is_create) begin
      case (svc)
        SVC_HASH: begin
          want_flf = HASH_FLF_LEN;
          algo_ok  = algo_offered({32'h0, HASH_ALGO_MASK}, req_buf[W_FLF0]);
        end
        SVC_MAC: begin
          want_flf = MAC_FLF_LEN;
          algo_ok  = algo_offered(MAC_ALGO_MASK, req_buf[W_FLF0]);
        end
        SVC_AEAD: begin
          want_flf = AEAD_FLF_LEN;
          algo_ok  = algo_offered({32'h0, AEAD_ALGO_MASK}, req_buf[W_ALGO]);
        end
        SVC_AKC: begin
          want_flf = AKC_FLF_LEN;
          algo_ok  = algo_offered({32'h0, AKC_ALGO_MASK}, req_buf[W_ALGO]);
        end
        default: begin
          want_flf = SYM_FLF_LEN;
          algo_ok  = algo_offered(CIPHER_ALGO_MASK, req_buf[W_ALGO]);
        end
      endcase
    end
    // Legacy layout pads every fixed area out to the same size
    if (!features[FEAT_REVISED]) begin
      want_flf = LEGACY_FLF_LEN;
    end
  end

  // Destroy handle lookup: handles are slot index plus one
  always_comb begin
    dest_handle = {req_buf[W_FLF1], req_buf[W_FLF0]};
    dest_idx    = IDX_W'(dest_handle[IDX_W-1:0] - 1'b1);
    dest_ok     = (dest_handle != 64'h0) &&
                  (dest_handle <= 64'(SESSIONS)) &&
                  pool_stat.valid[dest_idx] &&
                  (pool_stat.owner[dest_idx] == svc[2:0]);
  end

  // Interpreter: one cycle to judge the request and write the result
  always_comb begin
    next_state  = state;
    next_result = result;
    pool_req    = '0;
    case (state)
      ST_IDLE: begin
        if (go) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state         = ST_IDLE;
        next_result.handle = 64'h0;
        // Control requests never report auth or signature failures
        next_result.status = status_ok;
        if (!is_create && !is_destroy) begin
          next_result.status = status_unsupported;
        end else if (req_buf[W_FLAG][FLAG_STATELESS]) begin
          if (!features[FEAT_REVISED] || !features[svc[2:0]]) begin
            next_result.status = status_unsupported;
          end else begin
            // Parameters travel in the request; no table slot is held
            next_result.status = status_ok;
          end
        end else if (flf_len != want_flf) begin
          next_result.status = status_error;
        end else if (is_destroy) begin
          if (vlf_len != 16'h0000) begin
            next_result.status = status_error;
          end else if (!dest_ok) begin
            next_result.status = status_invalid_handle;
          end else begin
            pool_req.free  = 1'b1;
            pool_req.index = dest_idx;
          end
          // Destroy answers with a single status byte
          next_result.status[31:8] = 24'h0;
        end else if (!algo_ok) begin
          next_result.status = status_unsupported;
        end else if (svc == SVC_HASH && vlf_len != 16'h0000) begin
          next_result.status = status_error;
        end else if (svc == SVC_MAC &&
                     (req_buf[W_FLF2] > MAX_AUTH_KEY_LEN ||
                      {16'h0, vlf_len} != req_buf[W_FLF2])) begin
          next_result.status = status_error;
        end else if (!pool_stat.avail) begin
          // Without the revised layout a full table is a plain failure
          next_result.status = features[FEAT_REVISED] ?
                               status_no_free_handle : status_error;
        end else begin
          pool_req.alloc     = 1'b1;
          pool_req.index     = pool_stat.first;
          pool_req.service   = svc[2:0];
          next_result.handle = 64'(pool_stat.first) + 64'h1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state  <= ST_IDLE;
      result <= '0;
    end else begin
      state  <= next_state;
      result <= next_result;
    end
  end

  // Session table
  session_pool u_pool (
    .core_clk (core_clk),
    .resetn   (resetn),
    .req      (pool_req),
    .stat     (pool_stat)
  );

endmodule // crypto_session_control
`default_nettype wire

// ### guest_host.sv
// Guest driver model: an Avalon-MM master that stages control requests.
// Assumes one clock; the bench timeout ends any wait that never ends.
`timescale 1ns/1ps
`default_nettype none
module guest_host (
  // Clock
  input  wire logic        core_clk,
  // Avalon-MM master
  output var logic [7:0]   address,
  output var logic         read,
  output var logic         write,
  output var logic [31:0]  writedata,
  output var logic [3:0]   byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
  end

  // One access held until waitrequest is low; every word goes whole
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= we;
    read <= !we;
    // Slave sets the wait count; look at each rising edge, take data there
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~d; // Stale data not left on the bus
  endtask
endmodule // guest_host
`default_nettype wire

// ### session_pool.sv
// Session table: a valid bit and owning service for each handle slot.
// Assumes at most one allocate or free request per cycle from the interpreter.
`timescale 1ns/1ps
`default_nettype none
module session_pool
  import crypto_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  // Request and state
  input  wire crypto_ctrl_pkg::pool_req_t  req,
  output crypto_ctrl_pkg::pool_stat_t      stat
);
  import crypto_ctrl_pkg::*;

  logic [SESSIONS-1:0]      valid;
  logic [SESSIONS-1:0]      next_valid;
  logic [SESSIONS-1:0][2:0] owner;
  logic [SESSIONS-1:0][2:0] next_owner;

  // Allocate the requested slot or release one
  always_comb begin
    next_valid = valid;
    next_owner = owner;
    if (req.alloc) begin
      next_valid[req.index] = 1'b1;
      next_owner[req.index] = req.service;
    end else if (req.free) begin
      next_valid[req.index] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      valid <= '0;
      owner <= '0;
    end else begin
      valid <= next_valid;
      owner <= next_owner;
    end
  end

  // Lowest free slot, searched downward so the lowest index wins
  always_comb begin
    stat.avail = ~&valid;
    stat.first = '0;
    for (int i = SESSIONS - 1; i >= 0; i--) begin
      if (!valid[i]) begin
        stat.first = IDX_W'(i);
      end
    end
    stat.valid = valid;
    stat.owner = owner;
  end

endmodule // session_pool
`default_nettype wire

// ### testbench.sv
// Self-checking bench: control commands through the host model, checked
// against a reference session table. Assumes the package constants.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crypto_ctrl_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  address;
  logic        read, write, waitrequest, engine_ready, busy;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  int          err_count = 0, num_checks = 0, cyc = 0, seed = 71, feat = 0;
  int          own[8];

  crypto_session_control dut (.core_clk(core_clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .engine_ready(engine_ready), .busy(busy));
  guest_host host (.core_clk(core_clk), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest));

  initial forever #50 core_clk = ~core_clk;

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard, far above the expected few thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask

  // Reference outcome of one command; updates the session table
  function automatic int model(int op, al, fl, w4, w5, w6, fln, vl, output int h);
    int s, o, k, f, m, a;
    s = op >> 8;
    o = op & 255;
    h = 0;
    if (s > 4) return 3;
    k = (s == 4) ? (o == 4 ? 1 : o == 5 ? 2 : 0) : (o == 2 ? 1 : o == 3 ? 2 : 0);
    if (k == 0) return 3;
    if (fl & 1) return (feat[5] && feat[s]) ? 0 : 3;
    f = !feat[5] ? 56 : k == 2 ? 8 : s == 1 ? 8 : s == 2 ? 16 : s == 3 ? 24 : 56;
    if (fln != f) return 1;
    if (k == 2) begin
      if (vl != 0) return 1;
      if (w5 != 0 || w4 < 1 || w4 > 8 || own[w4-1] != s) return 4;
      own[w4-1] = -1;
      return 0;
    end
    m = (s < 2) ? 6 : (s == 2) ? 'h14 : 2;
    a = (s == 1 || s == 2) ? w4 : al;
    if (a > 31 || !m[a]) return 3;
    if (s == 1 && vl != 0) return 1;
    if (s == 2 && (w6 > 64 || vl != w6)) return 1;
    for (int i = 0; i < 8; i++) if (own[i] < 0) begin
      own[i] = s;
      h = i + 1;
      return 0;
    end
    return feat[5] ? 5 : 1;
  endfunction

  // Stage header and fixed words, start, poll done, check the result
  task automatic cmd(int op, al, fl, w4, w5, w6, fln, vl);
    int s, h;
    int w[7];
    logic [31:0] q;
    s = model(op, al, fl, w4, w5, w6, fln, vl, h);
    w = '{op, al, fl, 0, w4, w5, w6};
    for (int i = 0; i < 7; i++) host.xfer(1'b1, OFS_REQ_BUF + 8'(4 * i), w[i], q);
    host.xfer(1'b1, OFS_FLF_LEN, fln, q);
    host.xfer(1'b1, OFS_VLF_LEN, vl, q);
    host.xfer(1'b1, OFS_CONTROL, 32'h1, q);
    do host.xfer(1'b0, OFS_REQ_STATE, 32'h0, q); while (q[STATE_DONE_BIT] !== 1'b1);
    host.xfer(1'b0, OFS_RES_STATUS, 32'h0, q);
    cmp("status", s, q);
    host.xfer(1'b0, OFS_RES_HANDLE_LO, 32'h0, q);
    cmp("handle", h, q);
    host.xfer(1'b0, OFS_RES_HANDLE_HI, 32'h0, q);
    cmp("handle_hi", 0, q);
    host.xfer(1'b1, OFS_CONTROL, 32'h2, q);
  endtask

  task automatic mk(int s, int fln);
    cmd(s == 4 ? 'h404 : (s << 8) | 2, 1, 0, s == 2 ? 2 : 1, 0, 0, fln, 0);
  endtask

  task automatic kill(int s, int h, int fln);
    cmd(s == 4 ? 'h405 : (s << 8) | 3, 0, 0, h, 0, 0, fln, 0);
  endtask

  initial begin
    logic [31:0] q;
    static logic [7:0] ra[8] = '{8'h00, 8'h08, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h3C};
    static int rv[8] = '{1, 'h1F, 6, 'h14, 2, 2, 'h40, 0};
    static int ops[10] = '{'h002, 'h003, 'h102, 'h103, 'h202, 'h203, 'h302, 'h303, 'h404,
                           'h405};
    static int fls[4] = '{8, 16, 24, 56};
    int r;
    own = '{default: -1};
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Ready, service and algorithm masks before any command
    for (int i = 0; i < 8; i++) begin
      host.xfer(1'b0, ra[i], 32'h0, q);
      cmp("register", rv[i], q);
    end
    // Legacy layout: fill past full, then destroys with bad handles, one good handle and one bad length
    for (int i = 0; i < 10; i++) mk(i % 5, 56);
    kill(1, 3, 56);
    kill(2, 3, 56);
    kill(2, 3, 56);
    kill(0, 9, 56);
    kill(0, 0, 56);
    kill(0, 1, 8);
    // Revised layout with stateless hash only
    feat = 'h22;
    host.xfer(1'b1, OFS_FEATURES, 32'h22, q);
    mk(1, 56);
    mk(1, 8);
    mk(3, 24);
    cmd('h102, 0, 1, 1, 0, 0, 8, 0);
    cmd('h002, 1, 1, 1, 0, 0, 56, 0);
    cmd('h502, 1, 0, 1, 0, 0, 8, 0);
    cmd('h006, 1, 0, 1, 0, 0, 8, 0);
    cmd('h202, 0, 0, 2, 0, 65, 16, 65);
    for (int h = 1; h <= 8; h++) kill(own[h-1], h, 8);
    cmd('h202, 0, 0, 4, 0, 3, 16, 3);
    cmd('h202, 0, 0, 4, 0, 3, 16, 2);
    // Random mix of the ten service opcodes and small field values; word 5 stays zero
    for (int i = 0; i < 40; i++) begin
      r = $random(seed) & 32'h7FFFFFFF;
      cmd(ops[r % 10], (r >> 4) & 3, ((r >> 6) & 7) == 0, ((r >> 9) & 7) + 1, 0,
          (r >> 12) & 3, fls[(r >> 14) & 3], (r >> 16) & 3);
    end
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
